//--- fbms_cfg.svh
`ifndef FBMS_CFG_SVH
`define FBMS_CFG_SVH

// ==========================================================
// timing
`define FBMS_CLK_MHZ          200
`define FBMS_REFRESH_US       1000
`define FBMS_REFRESH_CYCLES   (`FBMS_REFRESH_US * `FBMS_CLK_MHZ)

// ==========================================================
// selection codes
`define FBMS_SEL_STATUS       4'h1
`define FBMS_SEL_POSITION     4'h2
`define FBMS_SEL_COUNTER      4'h3
`define FBMS_AUX_ARBITRARY    16'h0000
`define FBMS_AUX_SEQUENTIAL   16'h0001

// ==========================================================
// override error codes
`define FBMS_ERR_NORMAL       16'h0000
`define FBMS_ERR_PARSE        16'h1000
`define FBMS_ERR_NVM_BUSY     16'h2003

// ==========================================================
// drive alarm qualifying status-1 values
`define FBMS_ALARM_S1_A       8'h25
`define FBMS_ALARM_S1_B       8'h35
`define FBMS_ALARM_S1_C       8'h45
`define FBMS_ALARM_S1_D       8'h55

// ==========================================================
// word layout
`define FBMS_NUM_WORDS        16
`define FBMS_W_STAT_BASE      4
`define FBMS_W_ALARM          8
`define FBMS_W_POS_BASE       4
`define FBMS_W_POS_STAT       12

// firmware revision gating counter monitor, x100
`define FBMS_MIN_FW_REV       16'h01A9

`endif

//--- fbms_pkg.sv
package fbms_pkg;
    typedef logic [15:0] fbms_word_t;
    typedef logic [3:0]  fbms_sel_t;
    typedef enum logic [1:0] {
        FBMS_IDLE,
        FBMS_LOAD,
        FBMS_CHECK
    } fbms_phase_e;
endpackage

//--- fbms_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// send buffer write port and read port
interface fbms_buf_if;
    logic                 wr_en;
    logic [3:0]           wr_addr;
    fbms_pkg::fbms_word_t wr_data;
    logic [3:0]           rd_addr;
    fbms_pkg::fbms_word_t rd_data;
    modport writer (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem    (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- fbms_send_buf.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// sixteen-word send buffer, registered read
module fbms_send_buf (
    input  wire logic  clk,
    fbms_buf_if.mem    bus
);
    fbms_pkg::fbms_word_t mem_r [0:15];

    // write and registered read
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            mem_r[bus.wr_addr] <= bus.wr_data;
        end
        bus.rd_data <= mem_r[bus.rd_addr];
    end
endmodule
`default_nettype wire

//--- fbms_monitor_selector.sv
`timescale 1ns/100ps
`default_nettype none
`include "fbms_cfg.svh"
// Behaviour
// - override errors: 0000h ok, 1000h, 2003h
// - monitor words refresh from selection once per buffer reload
// - send buffer reloaded every millisecond
// - buffer loaded before check output updates
// - check output equals data selection input
// - 1 status, 2 position, 3 counter, rest reserved
// - counter monitor only from firmware 4.25
// - status layout: word0, zeros, status, alarm
// - alarm word only for 25h/35h/45h/55h
// - word 0 low byte echoes check value
// - status byte 0 flag bit meanings
// - status byte 2 operation mode encoding
// - position layout: word0, zeros, axes, status
// - coordinates signed 32-bit, 0.01 mm units
module fbms_monitor_selector #(
    parameter int unsigned REFRESH_CYCLES = `FBMS_REFRESH_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  data_select_input,
    input  wire logic [15:0] aux_select_word,
    input  wire logic [15:0] fw_revision,
    // status byte 0 flags
    input  wire logic        st_error,
    input  wire logic        st_executing,
    input  wire logic        st_paused,
    input  wire logic        st_homing,
    input  wire logic        st_homed,
    input  wire logic        st_in_position,
    input  wire logic        st_param2_modified,
    input  wire logic [7:0]  status1_code,
    // status byte 2 mode fields
    input  wire logic [1:0]  run_mode,
    input  wire logic [1:0]  exec_mode,
    input  wire logic        single_op_mode,
    input  wire logic        pulse_train_mode,
    input  wire logic        pendant_on,
    input  wire logic        host_on,
    input  wire logic        servo_on,
    input  wire logic [7:0]  drive_alarm_code,
    input  wire logic [31:0] axis1_pos,
    input  wire logic [31:0] axis2_pos,
    input  wire logic [31:0] axis3_pos,
    input  wire logic [31:0] axis4_pos,
    input  wire logic [255:0] counter_words,
    // override command result inputs
    input  wire logic        ovr_done,
    input  wire logic        ovr_parse_fail,
    input  wire logic        nvm_writing,
    output logic [3:0]       select_check_output,
    output logic [255:0]     response_words,
    output logic [15:0]      ovr_error_code,
    output logic             buffer_updated
);
    // ==========================================================
    // input synchronisers
    logic [3:0]  sel_s1_r, sel_s2_r;
    logic [15:0] aux_s1_r, aux_s2_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_s1_r <= 4'h0;
            sel_s2_r <= 4'h0;
            aux_s1_r <= 16'h0000;
            aux_s2_r <= 16'h0000;
        end else begin
            sel_s1_r <= data_select_input;
            sel_s2_r <= sel_s1_r;
            aux_s1_r <= aux_select_word;
            aux_s2_r <= aux_s1_r;
        end
    end

    // ==========================================================
    // millisecond tick
    logic [31:0] tick_cnt_r;
    logic        tick;
    assign tick = (tick_cnt_r == REFRESH_CYCLES - 1);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_r <= 32'h0;
        end else if (tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // ==========================================================
    // status bytes
    logic [7:0] stat0, stat1, stat2, stat3;
    logic       alarm_valid;
    assign stat0 = {st_param2_modified, 1'b0, st_in_position, st_homed,
                    st_homing, st_paused, st_executing, st_error};
    assign stat1 = status1_code;
    assign stat2 = {host_on, pendant_on, pulse_train_mode, single_op_mode,
                    exec_mode, run_mode};
    assign stat3 = {7'h00, servo_on};
    assign alarm_valid = (status1_code == `FBMS_ALARM_S1_A) || (status1_code == `FBMS_ALARM_S1_B)
                      || (status1_code == `FBMS_ALARM_S1_C) || (status1_code == `FBMS_ALARM_S1_D);

    // ==========================================================
    // load sequencer
    fbms_pkg::fbms_phase_e phase_r;
    logic [3:0]            widx_r;
    logic [3:0]            sel_lat_r;
    logic [15:0]           aux_lat_r;
    logic [3:0]            check_r;
    logic                  upd_r;
    logic                  cnt_ok;
    assign cnt_ok = (fw_revision >= `FBMS_MIN_FW_REV);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r   <= fbms_pkg::FBMS_IDLE;
            widx_r    <= 4'h0;
            sel_lat_r <= 4'h0;
            aux_lat_r <= 16'h0000;
        end else begin
            unique case (phase_r)
                fbms_pkg::FBMS_IDLE: begin
                    if (tick) begin
                        sel_lat_r <= sel_s2_r;
                        aux_lat_r <= aux_s2_r;
                        widx_r    <= 4'h0;
                        phase_r   <= fbms_pkg::FBMS_LOAD;
                    end
                end
                fbms_pkg::FBMS_LOAD: begin
                    widx_r <= widx_r + 4'h1;
                    if (widx_r == 4'hF) begin
                        phase_r <= fbms_pkg::FBMS_CHECK;
                    end
                end
                fbms_pkg::FBMS_CHECK: begin
                    // last word written; the read-back pipe drains from here
                    phase_r <= fbms_pkg::FBMS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // word formatter
    fbms_pkg::fbms_word_t word_val;
    logic [31:0]          pos_sel;
    logic [1:0]           axis_idx;
    logic                 cnt_sel;

    // counter monitor only on capable firmware and a known aux mode
    assign cnt_sel = (sel_lat_r == `FBMS_SEL_COUNTER) && cnt_ok
                  && (aux_lat_r == `FBMS_AUX_ARBITRARY || aux_lat_r == `FBMS_AUX_SEQUENTIAL);

    always_comb begin
        axis_idx = 2'(widx_r - 4'(`FBMS_W_POS_BASE) >> 1);
        unique case (axis_idx)
            2'h0: pos_sel = axis1_pos;
            2'h1: pos_sel = axis2_pos;
            2'h2: pos_sel = axis3_pos;
            default: pos_sel = axis4_pos;
        endcase
    end

    always_comb begin
        word_val = 16'h0000;
        if (widx_r == 4'h0) begin
            word_val = {8'h00, 4'h0, sel_lat_r};
            if (cnt_sel) begin
                word_val[11:8] = aux_lat_r[3:0]; // counter mode shown in the high byte
            end
        end else if (sel_lat_r == `FBMS_SEL_STATUS) begin
            if (widx_r == 4'h4) word_val = {8'h00, stat0};
            else if (widx_r == 4'h5) word_val = {8'h00, stat1};
            else if (widx_r == 4'h6) word_val = {8'h00, stat2};
            else if (widx_r == 4'h7) word_val = {8'h00, stat3};
            else if (widx_r == 4'(`FBMS_W_ALARM) && alarm_valid) word_val = {8'h00, drive_alarm_code};
        end else if (sel_lat_r == `FBMS_SEL_POSITION) begin
            if (widx_r >= 4'(`FBMS_W_POS_BASE) && widx_r < 4'(`FBMS_W_POS_STAT)) begin
                word_val = widx_r[0] ? pos_sel[31:16] : pos_sel[15:0];
            end else if (widx_r == 4'hC) word_val = {8'h00, stat0};
            else if (widx_r == 4'hD) word_val = {8'h00, stat1};
            else if (widx_r == 4'hE) word_val = {8'h00, stat2};
            else if (widx_r == 4'hF) word_val = {8'h00, stat3};
        end else if (cnt_sel) begin
            word_val = counter_words[{widx_r, 4'h0} +: 16];
        end
    end

    // ==========================================================
    // send buffer
    fbms_buf_if buf_bus ();
    assign buf_bus.wr_en   = (phase_r == fbms_pkg::FBMS_LOAD);
    assign buf_bus.wr_addr = widx_r;
    assign buf_bus.wr_data = word_val;
    assign buf_bus.rd_addr = widx_r - 4'h1; // read trails the write by one word

    fbms_send_buf u_buf (
        .clk (clk),
        .bus (buf_bus)
    );

    // ==========================================================
    // read-back tracking: which buffer word the read data holds
    // refresh period must exceed the 19-cycle load and drain
    logic       rd_vld_r;
    logic [3:0] rd_idx_r;
    logic [1:0] chk_dly_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_vld_r <= 1'b0;
            rd_idx_r <= 4'h0;
        end else begin
            rd_vld_r <= ((phase_r == fbms_pkg::FBMS_LOAD) && (widx_r != 4'h0))
                     || (phase_r == fbms_pkg::FBMS_CHECK);
            rd_idx_r <= widx_r - 4'h1;
        end
    end

    // ==========================================================
    // response words, copied from the send buffer as it is read back
    logic [255:0] resp_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp_r <= 256'h0;
        end else if (rd_vld_r) begin
            resp_r[{rd_idx_r, 4'h0} +: 16] <= buf_bus.rd_data;
        end
    end

    // ==========================================================
    // check output raised only after the last word has landed
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chk_dly_r <= 2'h0;
            check_r   <= 4'h0;
            upd_r     <= 1'b0;
        end else begin
            chk_dly_r <= {chk_dly_r[0], (phase_r == fbms_pkg::FBMS_CHECK)};
            upd_r     <= chk_dly_r[1];
            if (chk_dly_r[1]) begin
                check_r <= sel_lat_r;
            end
        end
    end

    // ==========================================================
    // override error code
    logic [15:0] ovr_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovr_r <= `FBMS_ERR_NORMAL;
        end else if (ovr_done) begin
            if (nvm_writing) ovr_r <= `FBMS_ERR_NVM_BUSY;
            else if (ovr_parse_fail) ovr_r <= `FBMS_ERR_PARSE;
            else ovr_r <= `FBMS_ERR_NORMAL;
        end
    end

    assign select_check_output = check_r;
    assign response_words      = resp_r;
    assign ovr_error_code      = ovr_r;
    assign buffer_updated      = upd_r;
endmodule
`default_nettype wire

//--- fbms_monitor_selector_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker for the monitor selector
module fbms_monitor_selector_props #(
    parameter int REFRESH_CYCLES = 50
) (
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire logic [7:0]   status1_code,
    input wire logic [31:0]  axis1_pos,
    input wire logic         ovr_done,
    input wire logic         ovr_parse_fail,
    input wire logic         nvm_writing,
    input wire logic [3:0]   select_check_output,
    input wire logic [255:0] response_words,
    input wire logic [15:0]  ovr_error_code,
    input wire logic         buffer_updated
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // refresh pulse timing and ordering
    AST_PERIOD: assert property (buffer_updated |-> ##[REFRESH_CYCLES:REFRESH_CYCLES] buffer_updated)
        else $error("refresh period wrong");
    AST_PULSE: assert property (buffer_updated |=> !buffer_updated)
        else $error("update pulse too long");
    AST_CHECK_HOLD: assert property (!buffer_updated |-> $stable(select_check_output))
        else $error("check changed outside update");
    AST_WORDS_FIRST: assert property (buffer_updated |-> $stable(response_words))
        else $error("words changed with check");
    AST_ECHO: assert property (buffer_updated |-> response_words[7:0] == {4'h0, select_check_output})
        else $error("word 0 does not echo check");
    // layouts per selection, then the override error code
    AST_STATUS_ZERO: assert property (buffer_updated && select_check_output == 4'h1
        |-> response_words[63:16] == '0 && response_words[255:144] == '0)
        else $error("status fixed words not zero");
    AST_ALARM: assert property (buffer_updated && select_check_output == 4'h1
        && !(status1_code inside {8'h25, 8'h35, 8'h45, 8'h55}) |-> response_words[143:128] == 16'h0000)
        else $error("alarm word filled wrongly");
    AST_POS_AXIS: assert property (buffer_updated && select_check_output == 4'h2
        |-> response_words[95:64] == axis1_pos && response_words[63:16] == '0)
        else $error("position layout wrong");
    AST_RESERVED: assert property (buffer_updated && (select_check_output == 4'h0 || select_check_output > 4'h3)
        |-> response_words[255:16] == '0)
        else $error("reserved code gave data");
    AST_OVR: assert property (ovr_done |-> ##1 ovr_error_code == ($past(nvm_writing) ? 16'h2003
        : ($past(ovr_parse_fail) ? 16'h1000 : 16'h0000)))
        else $error("override code wrong");
    // main scenarios reached
    COV_STATUS: cover property (buffer_updated && select_check_output == 4'h1);
    COV_POS: cover property (buffer_updated && select_check_output == 4'h2);
    COV_NVM: cover property (ovr_done && nvm_writing);
endmodule
bind fbms_monitor_selector fbms_monitor_selector_props #(.REFRESH_CYCLES(REFRESH_CYCLES)) props_u (
    .clk(clk), .sys_rst(sys_rst), .status1_code(status1_code), .axis1_pos(axis1_pos), .ovr_done(ovr_done),
    .ovr_parse_fail(ovr_parse_fail), .nvm_writing(nvm_writing), .select_check_output(select_check_output),
    .response_words(response_words), .ovr_error_code(ovr_error_code), .buffer_updated(buffer_updated));
`default_nettype wire

//--- fbms_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// master station: drives selection, trusts words on check match
module fbms_master_model (
    input  wire logic       clk,
    input  wire logic [3:0] select_check_output,
    input  wire logic       buffer_updated,
    output logic [3:0]      data_select_input,
    output logic [15:0]     aux_select_word
);
    logic ok;
    // idle selection at time zero
    initial begin
        data_select_input = 4'h0;
        aux_select_word = 16'h0000;
        ok = 1'b0;
    end
    // bounded wait for one update pulse
    task automatic wait_upd(output bit hit);
        hit = 0;
        for (int n = 0; n < 400 && !hit; n++) begin
            @(negedge clk);
            hit = (buffer_updated === 1'b1);
        end
    endtask
    // selection set after a pulse, words accepted on the next one
    task automatic apply(input logic [3:0] sel, input logic [15:0] aux);
        bit h;
        wait_upd(h);
        @(posedge clk);
        data_select_input <= sel;
        aux_select_word <= aux;
        wait_upd(h);
        ok = h && (select_check_output === sel);
    endtask
endmodule
`default_nettype wire

//--- fbms_monitor_selector_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// self-checking bench
module fbms_monitor_selector_bench;
    logic clk = 1'b0, sys_rst = 1'b1, b3 = 1'b1, done = 1'b0, parse = 1'b0, nvm = 1'b0;
    logic [7:0]   b0 = 8'hD5, b2 = 8'hA6, s1 = 8'h00, alm = 8'h5C;
    logic [15:0]  fw = 16'h01A9, ovr_err, ew [16];
    logic [3:0]   dsel, chk;
    logic [15:0]  aux;
    logic [31:0]  ax [4] = '{32'hFFFF_D8F0, 32'h0001_86A0, 32'h8000_0001, 32'h0000_0064};
    logic [255:0] cw, rw;
    logic         upd;
    int           error_cnt = 0, checks = 0;
    always #2.5 clk = ~clk;
    fbms_master_model mst_u (.clk(clk), .select_check_output(chk), .buffer_updated(upd),
        .data_select_input(dsel), .aux_select_word(aux));
    fbms_monitor_selector #(.REFRESH_CYCLES(50)) dut_u (.clk(clk), .sys_rst(sys_rst), .data_select_input(dsel),
        .aux_select_word(aux), .fw_revision(fw), .st_error(b0[0]), .st_executing(b0[1]), .st_paused(b0[2]),
        .st_homing(b0[3]), .st_homed(b0[4]), .st_in_position(b0[5]), .st_param2_modified(b0[7]),
        .status1_code(s1), .run_mode(b2[1:0]), .exec_mode(b2[3:2]), .single_op_mode(b2[4]),
        .pulse_train_mode(b2[5]), .pendant_on(b2[6]), .host_on(b2[7]), .servo_on(b3), .drive_alarm_code(alm),
        .axis1_pos(ax[0]), .axis2_pos(ax[1]), .axis3_pos(ax[2]), .axis4_pos(ax[3]), .counter_words(cw),
        .ovr_done(done), .ovr_parse_fail(parse), .nvm_writing(nvm), .select_check_output(chk),
        .response_words(rw), .ovr_error_code(ovr_err), .buffer_updated(upd));
    // comparisons
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %0t check %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_words(input logic [3:0] sel);
        for (int k = 0; k < 16; k++) cmp16(rw[16*k+:16], ew[k]);
        cmp4(chk, sel);
        cmp4({3'h0, mst_u.ok}, 4'h1);
    endtask
    task automatic stat_ew(input int b);
        ew[b] = {8'h00, b0 & 8'hBF};
        ew[b+1] = {8'h00, s1};
        ew[b+2] = {8'h00, b2};
        ew[b+3] = {15'h0000, b3};
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #60000;
        error_cnt++;
        end_of_test();
    end
    // test sequence
    initial begin
        logic [7:0]  codes [5] = '{8'h25, 8'h35, 8'h45, 8'h55, 8'h36};
        logic [15:0] cfw [4] = '{16'h01A9, 16'h01A9, 16'h01A8, 16'h01A9};
        logic [15:0] caux [4] = '{16'h0000, 16'h0001, 16'h0000, 16'h0002};
        logic [3:0]  rsv [4] = '{4'h0, 4'h4, 4'h9, 4'hF};
        for (int k = 0; k < 16; k++) cw[16*k+:16] = 16'hC000 + 16'(k);
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (codes[i]) begin
            @(posedge clk);
            s1 <= codes[i];
            mst_u.apply(4'h1, 16'h0000);
            ew = '{default: 16'h0000};
            ew[0] = 16'h0001;
            stat_ew(4);
            ew[8] = (i < 4) ? {8'h00, alm} : 16'h0000;
            chk_words(4'h1);
        end
        mst_u.apply(4'h2, 16'h0000);
        ew = '{default: 16'h0000};
        ew[0] = 16'h0002;
        for (int a = 0; a < 4; a++) {ew[5+2*a], ew[4+2*a]} = ax[a];
        stat_ew(12);
        chk_words(4'h2);
        foreach (cfw[i]) begin
            @(posedge clk);
            fw <= cfw[i];
            mst_u.apply(4'h3, caux[i]);
            ew = '{default: 16'h0000};
            ew[0] = 16'h0003;
            if (i < 2) begin
                for (int k = 1; k < 16; k++) ew[k] = cw[16*k+:16];
                ew[0][11:8] = caux[i][3:0];
            end
            chk_words(4'h3);
        end
        foreach (rsv[i]) begin
            mst_u.apply(rsv[i], 16'h0001);
            ew = '{default: 16'h0000};
            ew[0] = {12'h000, rsv[i]};
            chk_words(rsv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            done <= 1'b1;
            nvm <= i[1];
            parse <= i[0];
            @(posedge clk);
            done <= 1'b0;
            @(posedge clk);
            @(negedge clk);
            cmp16(ovr_err, i[1] ? 16'h2003 : (i[0] ? 16'h1000 : 16'h0000));
        end
        end_of_test();
    end
endmodule
`default_nettype wire
